// ---- hscr_top.sv ----
// Top of the high-speed serdes configuration register bank
// Function
// - PLL ratio codes 0010..1110 decode to 4x..25x; 0000, 0001, 1111 reserved.
// - Transmit swing code sits in bits 15:12, resets to 1010.
// - Transmit enable bit 11 resets to one; forced off by pin low or global bit.
// - Bit 10 freezes receive equalizer and long-tail correction; resets clear.
// - Transmit rate bits 9:8 pick full, half, quarter, eighth; reset 00.
// - Gain policy bits 7:6 choose four attenuator behaviours; reset 01.
// - Auto-zero bits 5:4 choose four calibration behaviours; reset 00.
// - Receive enable bit 3 resets to one; forced off by pin low or global bit.
// - Receive rate 000, 101, 110, 111 give full to eighth; others reserved.
// - Tuning bit 15 forces the receive converter into track mode; resets clear.
// - Precursor bits 14:12 give 1/9..13/9, 111 disables; reset 001.
// - Recovery order bits 11:10 give first, second 1x, second 2x; 11 reserved.
// - Vote threshold bits 9:8 give four to thirty-two votes; reset 01.
// - Tuning bit 6 turns off high-frequency peaking for slower links; resets clear.
// - Tuning bit 5 selects short-channel clock recovery; resets clear.
// - Cursor reduction bits 4:0 reset zero; codes 00111..01111 reserved.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module hscr_top
  import hscr_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire hscr_axi_req_type axi_req,
  output hscr_axi_rsp_type      axi_rsp,
  input  wire logic             channel_power_down_low,
  output hscr_enrate_type       fast_enrate_cfg,
  output hscr_tune_type         fast_tune_cfg,
  output logic [3:0]            fast_pll_ratio,
  output logic                  fast_tx_active,
  output logic                  fast_rx_active,
  output hscr_dec_type          fast_decoded
);

  // ==========================================================================
  // Declarations
  hscr_top_st_type q;
  hscr_top_st_type d;
  hscr_dec_type    dec_now;
  hscr_status_type status;
  logic            wr_go;
  logic [7:0]      wr_addr;
  logic [31:0]     wr_data;
  logic [3:0]      wr_strb;
  logic            wr_ok;
  logic [31:0]     rd_data;
  logic            rd_ok;
  logic            power_off;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] merge_lanes(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0])
      res[7:0] = data[7:0];
    if (strb[1])
      res[15:8] = data[15:8];
    return res;
  endfunction

  function automatic logic is_mapped(
    input logic [7:0] addr
  );
    return (addr == HSCR_TUNE_ADDR) || (addr == HSCR_ENRATE_ADDR) ||
           (addr == HSCR_PLL_ADDR) || (addr == HSCR_GLOBAL_ADDR) ||
           (addr == HSCR_STATUS_ADDR);
  endfunction

  // ==========================================================================
  // Bus front end and decode
  hscr_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .axi_req (axi_req),
    .axi_rsp (axi_rsp),
    .wr_go   (wr_go),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  hscr_decode u_decode (
    .pll_code (q.pll),
    .enrate   (q.enrate),
    .tune     (q.tune),
    .dec      (dec_now)
  );

  assign wr_ok = is_mapped(wr_addr);
  assign rd_ok = is_mapped(axi_req.araddr);

  // Either the pin or the global bit kills both directions
  assign power_off = !channel_power_down_low || q.gpd;

  // ==========================================================================
  // Status and read mux
  always_comb
  begin
    status              = '0;
    status.pin_low      = !channel_power_down_low;
    status.pll_quarters = q.dec.pll_quarters;
    status.cursor_rsvd  = q.dec.cursor_rsvd;
    status.order_rsvd   = q.dec.order_rsvd;
    status.rx_rate_rsvd = q.dec.rx_rate_rsvd;
    status.pll_rsvd     = q.dec.pll_rsvd;
    status.rx_active    = q.rx_active;
    status.tx_active    = q.tx_active;
  end

  always_comb
  begin
    rd_data = 32'h0;
    unique case (axi_req.araddr)
      HSCR_TUNE_ADDR:   rd_data = {16'h0000, q.tune};
      HSCR_ENRATE_ADDR: rd_data = {16'h0000, q.enrate};
      HSCR_PLL_ADDR:    rd_data = {28'h0000000, q.pll};
      HSCR_GLOBAL_ADDR: rd_data = {16'h0000, q.gpd, 15'h0000};
      HSCR_STATUS_ADDR: rd_data = {16'h0000, status};
      default:          rd_data = 32'h0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [15:0] pll_word;
    logic [15:0] glob_word;
    pll_word  = {12'h000, q.pll};
    glob_word = {q.gpd, 15'h0000};
    d         = q;
    if (wr_go)
    begin
      unique case (wr_addr)
        HSCR_TUNE_ADDR:
          d.tune = merge_lanes(q.tune, wr_data, wr_strb);
        HSCR_ENRATE_ADDR:
          d.enrate = merge_lanes(q.enrate, wr_data, wr_strb);
        HSCR_PLL_ADDR:
        begin
          pll_word = merge_lanes(pll_word, wr_data, wr_strb);
          d.pll    = pll_word[3:0];
        end
        HSCR_GLOBAL_ADDR:
        begin
          glob_word = merge_lanes(glob_word, wr_data, wr_strb);
          d.gpd     = glob_word[HSCR_GPD_BIT];
        end
        default:
          d.gpd = q.gpd;
      endcase
    end
    // Registered so the analog side never sees a decode glitch
    d.tx_active = q.enrate.fast_tx_on && !power_off;
    d.rx_active = q.enrate.fast_rx_on && !power_off;
    d.dec       = dec_now;
  end

  // Reserved codes pass through unchanged; their effect is undefined
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= HSCR_TOP_RST;
    else
      q <= d;
  end

  // ==========================================================================
  // Outputs
  assign fast_enrate_cfg = q.enrate;
  assign fast_tune_cfg   = q.tune;
  assign fast_pll_ratio  = q.pll;
  assign fast_tx_active  = q.tx_active;
  assign fast_rx_active  = q.rx_active;
  assign fast_decoded    = q.dec;

  // ==========================================================================
  // Assertions
  default clocking @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  sequence s_tune_low_write;
    wr_go && (wr_addr == HSCR_TUNE_ADDR) && wr_strb[0];
  endsequence

  sequence s_write_done;
    ##1 axi_rsp.bvalid;
  endsequence

  sequence s_gpd_set_write;
    wr_go && (wr_addr == HSCR_GLOBAL_ADDR) && wr_strb[1] && wr_data[HSCR_GPD_BIT];
  endsequence

  AST_PLL_LOW: assert property ((q.pll == 4'h2) |=> (q.dec.pll_quarters == 7'd16))
    else $error("PLL code 0010 did not decode to 4x");

  AST_PLL_RSVD: assert property ((q.pll == 4'hf) |=> q.dec.pll_rsvd)
    else $error("PLL code 1111 not flagged reserved");

  AST_RESET_VALUES: assert property ($rose(aresetn) |->
    (q.enrate == HSCR_ENRATE_RST) && (q.tune == HSCR_TUNE_RST))
    else $error("Register reset values wrong");

  AST_TX_OFF: assert property (power_off |=> !fast_tx_active)
    else $error("Transmitter active during power-down");

  AST_TX_ON: assert property ((aresetn && q.enrate.fast_tx_on && !power_off) |=>
    fast_tx_active)
    else $error("Transmitter not active when enabled");

  AST_RX_OFF: assert property (power_off |=> !fast_rx_active)
    else $error("Receiver active during power-down");

  AST_RX_FOLLOWS: assert property ($fell(q.enrate.fast_rx_on) |-> ##1 !fast_rx_active [*2])
    else $error("Receiver stays active after its enable cleared");

  AST_RX_HALF: assert property ((q.enrate.fast_rx_rate_sel == 3'h5) |=>
    (q.dec.rx_rate_shift == 2'd1) && !q.dec.rx_rate_rsvd)
    else $error("Receive rate 101 not decoded as half");

  AST_RX_RSVD: assert property ((q.enrate.fast_rx_rate_sel == 3'h1) |=> q.dec.rx_rate_rsvd)
    else $error("Receive rate 001 not flagged reserved");

  AST_PRE_OFF: assert property ((q.tune.fast_rx_precursor_level == 3'h7) |=>
    q.dec.precursor_off && (q.dec.precursor_ninths == 4'h0))
    else $error("Precursor code 111 did not disable");

  AST_PRE_TOP: assert property ((q.tune.fast_rx_precursor_level == 3'h6) |=>
    (q.dec.precursor_ninths == 4'd13))
    else $error("Precursor code 110 not 13/9");

  AST_ORDER_RSVD: assert property ((q.tune.recovery_loop_order == 2'h3) |=> q.dec.order_rsvd)
    else $error("Recovery order 11 not flagged reserved");

  AST_VOTES: assert property ((q.tune.recovery_vote_threshold == 2'h3) |=>
    (q.dec.vote_count == 6'd32))
    else $error("Vote threshold 11 not thirty-two");

  AST_CURSOR_TOP: assert property ((q.tune.tx_cursor_reduction == 5'h1f) |=>
    (q.dec.cursor_tenths == 10'd550) && !q.dec.cursor_rsvd)
    else $error("Cursor code 11111 not 55 percent");

  AST_CURSOR_RSVD: assert property ((q.tune.tx_cursor_reduction == 5'h07) |=>
    q.dec.cursor_rsvd)
    else $error("Cursor code 00111 not flagged reserved");

  AST_TUNE_WRITE: assert property (s_tune_low_write |=>
    (q.tune[7:0] == $past(wr_data[7:0])))
    else $error("Tuning low byte not written");

  AST_WRITE_RESP: assert property (wr_go |-> s_write_done)
    else $error("Write response missing one cycle after the write");

  AST_READ_RESP: assert property ((axi_req.arvalid && axi_rsp.arready) |=>
    axi_rsp.rvalid && !axi_rsp.arready)
    else $error("Read data not returned one cycle after address");

  AST_RX_ON: assert property ((aresetn && q.enrate.fast_rx_on && !power_off) |=>
    fast_rx_active)
    else $error("Receiver not active when enabled");

  AST_GPD_OFF: assert property (s_gpd_set_write |=> q.gpd ##1
    !(fast_tx_active || fast_rx_active))
    else $error("Global power-down left a direction active");

  AST_PLL_TOP: assert property ((q.pll == 4'he) |=> (q.dec.pll_quarters == 7'd100))
    else $error("PLL code 1110 not 25x");

  AST_PLL_FRACT: assert property ((q.pll == 4'h6) |=> (q.dec.pll_quarters == 7'd33))
    else $error("PLL code 0110 not 8.25x");

  AST_PLL_ZERO: assert property ((q.pll == 4'h0) |=> q.dec.pll_rsvd)
    else $error("PLL code 0000 not flagged reserved");

  AST_RX_FULL: assert property ((q.enrate.fast_rx_rate_sel == 3'h0) |=>
    (q.dec.rx_rate_shift == 2'd0) && !q.dec.rx_rate_rsvd)
    else $error("Receive rate 000 not decoded as full");

  AST_PRE_LOW: assert property ((q.tune.fast_rx_precursor_level == 3'h0) |=>
    (q.dec.precursor_ninths == 4'd1) && !q.dec.precursor_off)
    else $error("Precursor code 000 not 1/9");

  AST_ORDER_OK: assert property ((q.tune.recovery_loop_order != 2'h3) |=>
    !q.dec.order_rsvd)
    else $error("Legal recovery order flagged reserved");

  AST_VOTES_LOW: assert property ((q.tune.recovery_vote_threshold == 2'h0) |=>
    (q.dec.vote_count == 6'd4))
    else $error("Vote threshold 00 not four");

  AST_CURSOR_MID: assert property ((q.tune.tx_cursor_reduction == 5'h10) |=>
    (q.dec.cursor_tenths == 10'd170) && !q.dec.cursor_rsvd)
    else $error("Cursor code 10000 not 17 percent");

  AST_CURSOR_EDGE: assert property ((q.tune.tx_cursor_reduction == 5'h0f) |=>
    q.dec.cursor_rsvd)
    else $error("Cursor code 01111 not flagged reserved");

endmodule

// ---- hscr_pkg.sv ----
// Shared types and constants for the high-speed serdes configuration bank
package hscr_pkg;

  // ==========================================================================
  // Register map, byte addresses on the AXI4-Lite port
  localparam logic [7:0] HSCR_TUNE_ADDR   = 8'h04;
  localparam logic [7:0] HSCR_ENRATE_ADDR = 8'h08;
  localparam logic [7:0] HSCR_PLL_ADDR    = 8'h0c;
  localparam logic [7:0] HSCR_GLOBAL_ADDR = 8'h10;
  localparam logic [7:0] HSCR_STATUS_ADDR = 8'h14;

  localparam logic [1:0] HSCR_RESP_OKAY   = 2'h0;
  localparam logic [1:0] HSCR_RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register layouts, most significant field first
  typedef struct packed {
    logic [3:0] fast_tx_amplitude_code;
    logic       fast_tx_on;
    logic       fast_rx_eq_freeze;
    logic [1:0] fast_tx_rate_sel;
    logic [1:0] fast_rx_gain_policy;
    logic [1:0] fast_rx_autozero_policy;
    logic       fast_rx_on;
    logic [2:0] fast_rx_rate_sel;
  } hscr_enrate_type;

  typedef struct packed {
    logic       fast_rx_converter_track;
    logic [2:0] fast_rx_precursor_level;
    logic [1:0] recovery_loop_order;
    logic [1:0] recovery_vote_threshold;
    logic       spare_bit;
    logic       fast_rx_peaking_off;
    logic       short_channel_recovery;
    logic [4:0] tx_cursor_reduction;
  } hscr_tune_type;

  typedef struct packed {
    logic [6:0] pll_quarters;
    logic       pll_rsvd;
    logic [1:0] rx_rate_shift;
    logic       rx_rate_rsvd;
    logic [3:0] precursor_ninths;
    logic       precursor_off;
    logic       order_rsvd;
    logic [5:0] vote_count;
    logic [9:0] cursor_tenths;
    logic       cursor_rsvd;
  } hscr_dec_type;

  typedef struct packed {
    logic       pin_low;
    logic [6:0] pll_quarters;
    logic [1:0] zero;
    logic       cursor_rsvd;
    logic       order_rsvd;
    logic       rx_rate_rsvd;
    logic       pll_rsvd;
    logic       rx_active;
    logic       tx_active;
  } hscr_status_type;

  localparam hscr_enrate_type HSCR_ENRATE_RST = 16'ha848;
  localparam hscr_tune_type   HSCR_TUNE_RST   = 16'h1500;
  localparam logic [3:0]      HSCR_PLL_RST    = 4'hd;
  localparam int              HSCR_GPD_BIT    = 15;

  // ==========================================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } hscr_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } hscr_axi_rsp_type;

  typedef enum logic {HSCR_WR_OPEN = 1'b0, HSCR_WR_RESP = 1'b1} hscr_wr_phase_type;

  typedef struct packed {
    hscr_wr_phase_type phase;
    logic              awready;
    logic              wready;
    logic              arready;
    logic              rvalid;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } hscr_axil_st_type;

  localparam hscr_axil_st_type HSCR_AXIL_RST = '{phase: HSCR_WR_OPEN, awready: 1'b1,
    wready: 1'b1, arready: 1'b1, default: '0};

  typedef struct packed {
    hscr_enrate_type enrate;
    hscr_tune_type   tune;
    logic [3:0]      pll;
    logic            gpd;
    logic            tx_active;
    logic            rx_active;
    hscr_dec_type    dec;
  } hscr_top_st_type;

  localparam hscr_top_st_type HSCR_TOP_RST = '{enrate: HSCR_ENRATE_RST,
    tune: HSCR_TUNE_RST, pll: HSCR_PLL_RST, default: '0};

endpackage

// ---- hscr_axil_slave.sv ----
// AXI4-Lite slave front end for the serdes configuration bank
`timescale 1ns/1ps
module hscr_axil_slave
  import hscr_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire hscr_axi_req_type axi_req,
  output hscr_axi_rsp_type      axi_rsp,
  output logic                  wr_go,
  output logic [7:0]            wr_addr,
  output logic [31:0]           wr_data,
  output logic [3:0]            wr_strb,
  input  wire logic             wr_ok,
  input  wire logic [31:0]      rd_data,
  input  wire logic             rd_ok
);

  hscr_axil_st_type q;
  hscr_axil_st_type n;

  // Write fires once both halves are held and no response is pending
  assign wr_go   = (q.phase == HSCR_WR_OPEN) && !q.awready && !q.wready;
  assign wr_addr = q.awaddr;
  assign wr_data = q.wdata;
  assign wr_strb = q.wstrb;

  always_comb
  begin
    n = q;
    if (axi_req.awvalid && q.awready)
    begin
      n.awready = 1'b0;
      n.awaddr  = axi_req.awaddr;
    end
    if (axi_req.wvalid && q.wready)
    begin
      n.wready = 1'b0;
      n.wdata  = axi_req.wdata;
      n.wstrb  = axi_req.wstrb;
    end
    unique case (q.phase)
      HSCR_WR_OPEN:
      begin
        if (wr_go)
        begin
          n.phase = HSCR_WR_RESP;
          n.bresp = wr_ok ? HSCR_RESP_OKAY : HSCR_RESP_SLVERR;
        end
      end
      HSCR_WR_RESP:
      begin
        if (axi_req.bready)
        begin
          n.phase   = HSCR_WR_OPEN;
          n.awready = 1'b1;
          n.wready  = 1'b1;
        end
      end
    endcase
    if (axi_req.arvalid && q.arready)
    begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rdata   = rd_data;
      n.rresp   = rd_ok ? HSCR_RESP_OKAY : HSCR_RESP_SLVERR;
    end
    if (q.rvalid && axi_req.rready)
    begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= HSCR_AXIL_RST;
    else
      q <= n;
  end

  assign axi_rsp = '{awready: q.awready, wready: q.wready,
    bvalid: (q.phase == HSCR_WR_RESP), bresp: q.bresp, arready: q.arready,
    rvalid: q.rvalid, rdata: q.rdata, rresp: q.rresp};

endmodule

// ---- hscr_decode.sv ----
// Combinational decode of the serdes configuration codes
`timescale 1ns/1ps
module hscr_decode
  import hscr_pkg::*;
(
  input  wire logic [3:0]      pll_code,
  input  wire hscr_enrate_type enrate,
  input  wire hscr_tune_type   tune,
  output hscr_dec_type         dec
);

  always_comb
  begin
    dec = '0;
    // Ratio in quarter steps so that 8.25x and 16.5x stay exact
    unique case (pll_code)
      4'h2: dec.pll_quarters = 7'd16;
      4'h3: dec.pll_quarters = 7'd20;
      4'h4: dec.pll_quarters = 7'd24;
      4'h5: dec.pll_quarters = 7'd32;
      4'h6: dec.pll_quarters = 7'd33;
      4'h7: dec.pll_quarters = 7'd40;
      4'h8: dec.pll_quarters = 7'd48;
      4'h9: dec.pll_quarters = 7'd50;
      4'ha: dec.pll_quarters = 7'd60;
      4'hb: dec.pll_quarters = 7'd64;
      4'hc: dec.pll_quarters = 7'd66;
      4'hd: dec.pll_quarters = 7'd80;
      4'he: dec.pll_quarters = 7'd100;
      default: dec.pll_rsvd = 1'b1;
    endcase
    unique case (enrate.fast_rx_rate_sel)
      3'h0: dec.rx_rate_shift = 2'd0;
      3'h5: dec.rx_rate_shift = 2'd1;
      3'h6: dec.rx_rate_shift = 2'd2;
      3'h7: dec.rx_rate_shift = 2'd3;
      default: dec.rx_rate_rsvd = 1'b1;
    endcase
    dec.precursor_off    = (tune.fast_rx_precursor_level == 3'h7);
    dec.precursor_ninths = dec.precursor_off ? 4'h0 : {tune.fast_rx_precursor_level, 1'b1};
    dec.order_rsvd       = (tune.recovery_loop_order == 2'h3);
    dec.vote_count       = 6'd4 << tune.recovery_vote_threshold;
    // Cursor reduction in tenths of a percent
    unique case (tune.tx_cursor_reduction)
      5'h00: dec.cursor_tenths = 10'd0;
      5'h01: dec.cursor_tenths = 10'd25;
      5'h02: dec.cursor_tenths = 10'd50;
      5'h03: dec.cursor_tenths = 10'd75;
      5'h04: dec.cursor_tenths = 10'd100;
      5'h05: dec.cursor_tenths = 10'd120;
      5'h06: dec.cursor_tenths = 10'd150;
      5'h10: dec.cursor_tenths = 10'd170;
      5'h11: dec.cursor_tenths = 10'd200;
      5'h12: dec.cursor_tenths = 10'd220;
      5'h13: dec.cursor_tenths = 10'd250;
      5'h14: dec.cursor_tenths = 10'd270;
      5'h15: dec.cursor_tenths = 10'd300;
      5'h16: dec.cursor_tenths = 10'd320;
      5'h17: dec.cursor_tenths = 10'd350;
      5'h18: dec.cursor_tenths = 10'd370;
      5'h19: dec.cursor_tenths = 10'd400;
      5'h1a: dec.cursor_tenths = 10'd420;
      5'h1b: dec.cursor_tenths = 10'd450;
      5'h1c: dec.cursor_tenths = 10'd470;
      5'h1d: dec.cursor_tenths = 10'd500;
      5'h1e: dec.cursor_tenths = 10'd520;
      5'h1f: dec.cursor_tenths = 10'd550;
      default: dec.cursor_rsvd = 1'b1;
    endcase
  end

endmodule

// ---- hs_serdes_config_regs_tb.sv ----
// Self-checking testbench for the serdes configuration register bank
`timescale 1ns/1ps
module hs_serdes_config_regs_tb
  import hscr_pkg::*;
;
  logic             aclk;
  logic             aresetn;
  logic             channel_power_down_low;
  hscr_axi_req_type req;
  hscr_axi_rsp_type rsp;
  hscr_enrate_type  enrate_cfg;
  hscr_enrate_type  e;
  hscr_tune_type    tune_cfg;
  hscr_tune_type    t;
  logic [3:0]       pll_ratio;
  logic             tx_active;
  logic             rx_active;
  hscr_dec_type     decoded;
  logic [31:0]      rd;
  logic [1:0]       rs;
  int               err_count;
  int               check_count;
  int               cycles;
  logic [6:0]       pll_q [16] = '{0, 0, 16, 20, 24, 32, 33, 40, 48, 50, 60, 64, 66, 80, 100, 0};
  logic [1:0]       rx_sh [8] = '{0, 0, 0, 0, 0, 1, 2, 3};
  logic [9:0]       cur [32] = '{0, 25, 50, 75, 100, 120, 150, 0, 0, 0, 0, 0, 0, 0, 0, 0,
    170, 200, 220, 250, 270, 300, 320, 350, 370, 400, 420, 450, 470, 500, 520, 550};

  hscr_top u_dut (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .axi_req                (req),
    .axi_rsp                (rsp),
    .channel_power_down_low (channel_power_down_low),
    .fast_enrate_cfg        (enrate_cfg),
    .fast_tune_cfg          (tune_cfg),
    .fast_pll_ratio         (pll_ratio),
    .fast_tx_active         (tx_active),
    .fast_rx_active         (rx_active),
    .fast_decoded           (decoded)
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // ==========================================================================
  // Checking and closing
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the tests need
  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================================
  // AXI4-Lite master; handshakes are judged at the falling edge so that the
  // values seen are the ones the next rising edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw;
    logic w;
    logic ta;
    logic tw;
    aw = 1'b0;
    w  = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    while (!(aw && w))
    begin
      @(negedge aclk);
      ta = !aw && rsp.awready === 1'b1;
      tw = !w && rsp.wready === 1'b1;
      @(posedge aclk);
      if (ta)
      begin
        req.awvalid <= 1'b0;
        aw = 1'b1;
      end
      if (tw)
      begin
        req.wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    rs = 2'bxx;
    forever
    begin
      @(negedge aclk);
      if (rsp.bvalid === 1'b1)
      begin
        rs = rsp.bresp;
        break;
      end
    end
    @(posedge aclk);
    req.bready <= 1'b0;
    chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    forever
    begin
      @(negedge aclk);
      if (rsp.arready === 1'b1)
        break;
    end
    @(posedge aclk);
    req.arvalid <= 1'b0;
    rd = 32'hxxxxxxxx;
    rs = 2'bxx;
    forever
    begin
      @(negedge aclk);
      if (rsp.rvalid === 1'b1)
      begin
        rd = rsp.rdata;
        rs = rsp.rresp;
        break;
      end
    end
    @(posedge aclk);
    req.rready <= 1'b0;
    chk(rd, exp);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  // Decoded and active outputs trail a register write by one edge; two give margin
  task automatic settle();
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    req = '0;
    channel_power_down_low = 1'b1;
    aresetn = 1'b0;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;

    rdchk(HSCR_TUNE_ADDR, 32'h1500, HSCR_RESP_OKAY);
    rdchk(HSCR_ENRATE_ADDR, 32'ha848, HSCR_RESP_OKAY);
    rdchk(HSCR_PLL_ADDR, 32'hd, HSCR_RESP_OKAY);
    chk({31'h0, tx_active}, 32'h1);
    chk({31'h0, rx_active}, 32'h1);
    chk({26'h0, decoded.vote_count}, 32'd8);
    $display("test reset values done");

    for (int i = 0; i < 16; i++)
    begin
      wr(HSCR_PLL_ADDR, i, 4'hf, HSCR_RESP_OKAY);
      settle();
      chk({28'h0, pll_ratio}, i);
      chk({25'h0, decoded.pll_quarters}, {25'h0, pll_q[i]});
      chk({31'h0, decoded.pll_rsvd}, {31'h0, (i < 2 || i == 15)});
    end
    $display("test pll ratio done");

    for (int i = 0; i < 8; i++)
    begin
      wr(HSCR_ENRATE_ADDR, 32'ha848 | i, 4'h3, HSCR_RESP_OKAY);
      settle();
      chk({30'h0, decoded.rx_rate_shift}, {30'h0, rx_sh[i]});
      chk({31'h0, decoded.rx_rate_rsvd}, {31'h0, (i >= 1 && i <= 4)});
    end
    for (int i = 0; i < 4; i++)
    begin
      e = HSCR_ENRATE_RST;
      e.fast_tx_amplitude_code = 4'(12 - i);
      e.fast_rx_eq_freeze = i[0];
      e.fast_tx_rate_sel = i[1:0];
      e.fast_rx_gain_policy = 2'(3 - i);
      e.fast_rx_autozero_policy = i[1:0];
      wr(HSCR_ENRATE_ADDR, {16'h0, e}, 4'h3, HSCR_RESP_OKAY);
      rdchk(HSCR_ENRATE_ADDR, {16'h0, e}, HSCR_RESP_OKAY);
      chk({16'h0, enrate_cfg}, {16'h0, e});
    end
    $display("test enable and rate done");

    for (int i = 0; i < 8; i++)
    begin
      t = HSCR_TUNE_RST;
      t.fast_rx_converter_track = i[0];
      t.fast_rx_precursor_level = i[2:0];
      t.recovery_loop_order = i[1:0];
      t.recovery_vote_threshold = i[1:0];
      t.fast_rx_peaking_off = i[1];
      t.short_channel_recovery = i[2];
      wr(HSCR_TUNE_ADDR, {16'h0, t}, 4'h3, HSCR_RESP_OKAY);
      settle();
      chk({16'h0, tune_cfg}, {16'h0, t});
      chk({31'h0, decoded.precursor_off}, {31'h0, (i == 7)});
      if (i < 7)
        chk({28'h0, decoded.precursor_ninths}, 2 * i + 1);
      chk({31'h0, decoded.order_rsvd}, {31'h0, (i % 4 == 3)});
      chk({26'h0, decoded.vote_count}, 4 << (i % 4));
    end
    for (int i = 0; i < 32; i++)
    begin
      wr(HSCR_TUNE_ADDR, 32'h1500 | i, 4'h3, HSCR_RESP_OKAY);
      settle();
      chk({22'h0, decoded.cursor_tenths}, {22'h0, cur[i]});
      chk({31'h0, decoded.cursor_rsvd}, {31'h0, (i >= 7 && i <= 15)});
    end
    $display("test tuning done");

    wr(HSCR_ENRATE_ADDR, 32'ha848, 4'h3, HSCR_RESP_OKAY);
    @(posedge aclk);
    channel_power_down_low <= 1'b0;
    settle();
    chk({30'h0, tx_active, rx_active}, 32'h0);
    rdchk(HSCR_STATUS_ADDR, {16'h0, 1'b1, pll_q[15], 8'h04}, HSCR_RESP_OKAY);
    @(posedge aclk);
    channel_power_down_low <= 1'b1;
    settle();
    chk({30'h0, tx_active, rx_active}, 32'h3);
    wr(HSCR_GLOBAL_ADDR, 32'h8000, 4'h3, HSCR_RESP_OKAY);
    settle();
    chk({30'h0, tx_active, rx_active}, 32'h0);
    wr(HSCR_GLOBAL_ADDR, 32'h0, 4'h3, HSCR_RESP_OKAY);
    settle();
    chk({30'h0, tx_active, rx_active}, 32'h3);
    wr(HSCR_ENRATE_ADDR, 32'ha040, 4'h3, HSCR_RESP_OKAY);
    settle();
    chk({30'h0, tx_active, rx_active}, 32'h0);
    $display("test power down done");

    // Unmapped place, read-only status, byte lanes and upper half
    wr(8'h18, 32'h1234, 4'hf, HSCR_RESP_SLVERR);
    rdchk(8'h18, 32'h0, HSCR_RESP_SLVERR);
    wr(HSCR_STATUS_ADDR, 32'hffff, 4'hf, HSCR_RESP_OKAY);
    wr(HSCR_TUNE_ADDR, 32'hffff00aa, 4'h1, HSCR_RESP_OKAY);
    rdchk(HSCR_TUNE_ADDR, 32'h15aa, HSCR_RESP_OKAY);
    $display("test refusals done");
    end_sim();
  end
endmodule
